// ### hdl/psemc_defs.svh
// offsets, field positions, reset values and widths of the symbol error / crossover block
`ifndef PSEMC_DEFS_SVH
`define PSEMC_DEFS_SVH

// register indices; byte address is four times the index
`define PSEMC_IDX_SYMBOL_ERROR_COUNT 6'h1A
`define PSEMC_IDX_SPECIAL_CONTROL 6'h1B
`define PSEMC_IDX_IRQ_STATUS 6'h1C
`define PSEMC_IDX_IRQ_MASK 6'h1D

// field positions of special_control_status
`define PSEMC_BIT_CROSSOVER_SOURCE 15
`define PSEMC_BIT_CROSSOVER_ENABLE 14
`define PSEMC_BIT_CROSSOVER_STATE 13
`define PSEMC_BIT_HEARTBEAT_DISABLE 11
`define PSEMC_BIT_FAR_END_FAULT 5
`define PSEMC_BIT_POLARITY 4

// reset values
`define PSEMC_RST_SYMBOL_ERROR_COUNT 16'h0000
`define PSEMC_RST_CROSSOVER_SOURCE 1'h0
`define PSEMC_RST_CROSSOVER_ENABLE 1'h0
`define PSEMC_RST_CROSSOVER_STATE 1'h0
`define PSEMC_RST_HEARTBEAT_DISABLE 1'h0
`define PSEMC_RST_FAR_END_FAULT 1'h0
`define PSEMC_RST_POLARITY 1'h0
`define PSEMC_RST_IRQ_STATUS 3'h0
`define PSEMC_RST_IRQ_MASK 3'h0

// interrupt status / mask layout
`define PSEMC_IRQ_WIDTH 3
`define PSEMC_IRQ_BIT_COUNT 0
`define PSEMC_IRQ_BIT_WRAP 1
`define PSEMC_IRQ_BIT_POLARITY 2

`endif

// ### hdl/psemc_pkg.sv
// types shared by the symbol error / crossover control block
package psemc_pkg;

    typedef enum logic [1:0] {
        mdix_straight,
        mdix_crossed,
        mdix_auto
    } psemc_mdix_t;

    typedef enum logic [1:0] {
        pkt_idle,
        pkt_clean,
        pkt_counted
    } psemc_pkt_state_t;

endpackage : psemc_pkg

// ### hdl/psemc_regs.sv
// symbol error counter and special control/status registers on APB
`timescale 1ns/1ps
`include "psemc_defs.svh"
module psemc_regs #(
    parameter int COUNT_WIDTH = 16,
    parameter int ADDR_WIDTH = 8
) (
    // clock and chip-level reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port mode and soft reset
    input wire logic phy_soft_reset,
    input wire logic fiber_mode_strap,
    input wire logic mode_100tx,
    input wire logic mode_10t,
    // receive symbols
    input wire logic rx_symbol_valid,
    input wire logic rx_symbol_invalid,
    input wire logic rx_packet_active,
    input wire logic rx_polarity_reversed,
    // physical layer controls
    output logic mdix_auto,
    output logic mdix_crossed,
    output logic heartbeat_test_enable,
    output logic far_end_fault_gen_enable,
    output logic far_end_fault_det_enable,
    // interrupt
    output logic irq
);

    generate
        if (COUNT_WIDTH != 16) begin : g_bad_count
            $error("psemc_regs: COUNT_WIDTH must be 16 to fit its register");
        end
        if (ADDR_WIDTH < 8) begin : g_bad_addr
            $error("psemc_regs: ADDR_WIDTH must be at least 8");
        end
    endgenerate

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic setup_phase;
    logic access_phase;
    logic [5:0] word_idx;
    logic sel_count;
    logic sel_special;
    logic sel_status;
    logic sel_mask;
    logic addr_hit;
    logic wr_low;
    logic wr_high;
    logic wr_special;
    logic wr_status;
    logic wr_mask;

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign word_idx = paddr[7:2];
    assign sel_count = (word_idx == `PSEMC_IDX_SYMBOL_ERROR_COUNT);
    assign sel_special = (word_idx == `PSEMC_IDX_SPECIAL_CONTROL);
    assign sel_status = (word_idx == `PSEMC_IDX_IRQ_STATUS);
    assign sel_mask = (word_idx == `PSEMC_IDX_IRQ_MASK);
    // upper address bits must be zero too
    assign addr_hit = (sel_count | sel_special | sel_status | sel_mask)
                    & (paddr[1:0] == 2'h0)
                    & ~(|(paddr >> 8));
    assign wr_low = access_phase & pwrite & addr_hit & pstrb[0];
    assign wr_high = access_phase & pwrite & addr_hit & pstrb[1];
    // count register has no write path at all
    assign wr_special = sel_special;
    assign wr_status = sel_status & wr_low;
    assign wr_mask = sel_mask & wr_low;

    // zero wait states; data was captured in the setup cycle
    assign pready = access_phase;
    assign pslverr = access_phase & ~addr_hit;

    // ------------------------------------------------------------------
    // symbol error counter
    // ------------------------------------------------------------------
    logic [COUNT_WIDTH-1:0] sym_count;
    logic sym_incr;
    logic sym_wrap;
    logic count_allow;

    assign count_allow = mode_100tx & ~mode_10t;

    psemc_symbol_counter #(
        .WIDTH(COUNT_WIDTH)
    ) u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .soft_clear(phy_soft_reset),
        .count_allow(count_allow),
        .sym_valid(rx_symbol_valid),
        .sym_invalid(rx_symbol_invalid),
        .pkt_active(rx_packet_active),
        .count(sym_count),
        .incr_pulse(sym_incr),
        .wrap_pulse(sym_wrap)
    );

    // ------------------------------------------------------------------
    // special control/status: soft-reset-proof bits
    // ------------------------------------------------------------------
    logic xover_src_ff;
    logic xover_en_ff;
    logic xover_state_ff;
    logic sqe_off_ff;
    logic nxt_xover_src;
    logic nxt_xover_en;
    logic nxt_xover_state;
    logic nxt_sqe_off;

    // soft reset deliberately leaves these alone
    always_comb begin
        nxt_xover_src = xover_src_ff;
        nxt_xover_en = xover_en_ff;
        nxt_xover_state = xover_state_ff;
        nxt_sqe_off = sqe_off_ff;
        if (wr_special & wr_high) begin
            nxt_xover_src = pwdata[`PSEMC_BIT_CROSSOVER_SOURCE];
            nxt_xover_en = pwdata[`PSEMC_BIT_CROSSOVER_ENABLE];
            nxt_xover_state = pwdata[`PSEMC_BIT_CROSSOVER_STATE];
            nxt_sqe_off = pwdata[`PSEMC_BIT_HEARTBEAT_DISABLE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xover_src_ff <= `PSEMC_RST_CROSSOVER_SOURCE;
            xover_en_ff <= `PSEMC_RST_CROSSOVER_ENABLE;
            xover_state_ff <= `PSEMC_RST_CROSSOVER_STATE;
            sqe_off_ff <= `PSEMC_RST_HEARTBEAT_DISABLE;
        end else begin
            xover_src_ff <= nxt_xover_src;
            xover_en_ff <= nxt_xover_en;
            xover_state_ff <= nxt_xover_state;
            sqe_off_ff <= nxt_sqe_off;
        end
    end

    // ------------------------------------------------------------------
    // special control/status: far-end fault and polarity
    // ------------------------------------------------------------------
    logic fefi_ff;
    logic nxt_fefi;
    logic strap_done_ff;
    logic nxt_strap_done;
    logic polarity_ff;
    logic nxt_polarity;

    // the strap is a port, so it is loaded one clock after release, not in reset
    always_comb begin
        nxt_fefi = fefi_ff;
        nxt_strap_done = 1'b1;
        nxt_polarity = polarity_ff;
        if (!strap_done_ff || phy_soft_reset) begin
            nxt_fefi = fiber_mode_strap;
        end else if (wr_special & wr_low) begin
            nxt_fefi = pwdata[`PSEMC_BIT_FAR_END_FAULT];
        end
        if (phy_soft_reset) begin
            nxt_polarity = `PSEMC_RST_POLARITY;
        end else if (mode_10t) begin
            nxt_polarity = rx_polarity_reversed;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fefi_ff <= `PSEMC_RST_FAR_END_FAULT;
            strap_done_ff <= 1'b0;
            polarity_ff <= `PSEMC_RST_POLARITY;
        end else begin
            fefi_ff <= nxt_fefi;
            strap_done_ff <= nxt_strap_done;
            polarity_ff <= nxt_polarity;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    logic [`PSEMC_IRQ_WIDTH-1:0] irq_status_ff;
    logic [`PSEMC_IRQ_WIDTH-1:0] nxt_irq_status;
    logic [`PSEMC_IRQ_WIDTH-1:0] irq_mask_ff;
    logic [`PSEMC_IRQ_WIDTH-1:0] nxt_irq_mask;
    logic [`PSEMC_IRQ_WIDTH-1:0] irq_events;
    logic [`PSEMC_IRQ_WIDTH-1:0] irq_clear;

    always_comb begin
        irq_events = '0;
        irq_events[`PSEMC_IRQ_BIT_COUNT] = sym_incr;
        irq_events[`PSEMC_IRQ_BIT_WRAP] = sym_wrap;
        irq_events[`PSEMC_IRQ_BIT_POLARITY] = nxt_polarity ^ polarity_ff;
        irq_clear = wr_status ? pwdata[`PSEMC_IRQ_WIDTH-1:0] : '0;
        // an event landing with its clear stays set
        nxt_irq_status = (irq_status_ff & ~irq_clear) | irq_events;
        nxt_irq_mask = wr_mask ? pwdata[`PSEMC_IRQ_WIDTH-1:0] : irq_mask_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= `PSEMC_RST_IRQ_STATUS;
            irq_mask_ff <= `PSEMC_RST_IRQ_MASK;
        end else begin
            irq_status_ff <= nxt_irq_status;
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    assign irq = |(irq_status_ff & irq_mask_ff);

    // ------------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------------
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic [15:0] special_word;

    always_comb begin
        special_word = 16'h0000;
        special_word[`PSEMC_BIT_CROSSOVER_SOURCE] = xover_src_ff;
        special_word[`PSEMC_BIT_CROSSOVER_ENABLE] = xover_en_ff;
        special_word[`PSEMC_BIT_CROSSOVER_STATE] = xover_state_ff;
        special_word[`PSEMC_BIT_HEARTBEAT_DISABLE] = sqe_off_ff;
        special_word[`PSEMC_BIT_FAR_END_FAULT] = fefi_ff;
        special_word[`PSEMC_BIT_POLARITY] = polarity_ff;
        nxt_prdata = prdata_ff;
        if (setup_phase && !pwrite) begin
            nxt_prdata = 32'h0000_0000;
            if (!addr_hit) begin
                // refused reads give zero even when the word index matches
                nxt_prdata = 32'h0000_0000;
            end else if (sel_count) begin
                // reading has no side effect on the count
                nxt_prdata[15:0] = sym_count;
            end else if (sel_special) begin
                nxt_prdata[15:0] = special_word;
            end else if (sel_status) begin
                nxt_prdata[`PSEMC_IRQ_WIDTH-1:0] = irq_status_ff;
            end else if (sel_mask) begin
                nxt_prdata[`PSEMC_IRQ_WIDTH-1:0] = irq_mask_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;

    // ------------------------------------------------------------------
    // crossover and physical layer controls
    // ------------------------------------------------------------------
    psemc_pkg::psemc_mdix_t mdix_mode;

    // the reserved 11 code falls back to automatic as the least harmful choice
    always_comb begin
        if (!xover_src_ff) begin
            mdix_mode = psemc_pkg::mdix_auto;
        end else begin
            case ({xover_en_ff, xover_state_ff})
                2'h0: mdix_mode = psemc_pkg::mdix_straight;
                2'h1: mdix_mode = psemc_pkg::mdix_crossed;
                2'h2: mdix_mode = psemc_pkg::mdix_auto;
                default: mdix_mode = psemc_pkg::mdix_auto;
            endcase
        end
    end

    assign mdix_auto = (mdix_mode == psemc_pkg::mdix_auto);
    assign mdix_crossed = (mdix_mode == psemc_pkg::mdix_crossed);
    assign heartbeat_test_enable = ~sqe_off_ff;
    assign far_end_fault_gen_enable = fefi_ff;
    assign far_end_fault_det_enable = fefi_ff;

endmodule : psemc_regs

// ### hdl/psemc_symbol_counter.sv
// symbol error counter, one per packet or per idle error, with wrap-around
`timescale 1ns/1ps
module psemc_symbol_counter #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_clear,
    // receive symbol stream
    input wire logic count_allow,
    input wire logic sym_valid,
    input wire logic sym_invalid,
    input wire logic pkt_active,
    // result
    output logic [WIDTH-1:0] count,
    output logic incr_pulse,
    output logic wrap_pulse
);

    generate
        if (WIDTH < 2) begin : g_bad_width
            $error("psemc_symbol_counter: WIDTH must be at least 2");
        end
    endgenerate

    psemc_pkg::psemc_pkt_state_t state_ff;
    psemc_pkg::psemc_pkt_state_t nxt_state;
    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;
    logic incr_ff;
    logic nxt_incr;
    logic wrap_ff;
    logic nxt_wrap;
    logic hit;
    logic bump;

    // frozen outside 100 Mb/s twisted-pair receive
    assign hit = count_allow & sym_valid & sym_invalid;

    always_comb begin
        nxt_state = state_ff;
        bump = 1'b0;
        case (state_ff)
            psemc_pkg::pkt_idle: begin
                // idle errors count one each
                bump = hit;
                if (pkt_active) begin
                    nxt_state = hit ? psemc_pkg::pkt_counted : psemc_pkg::pkt_clean;
                end
            end
            psemc_pkg::pkt_clean: begin
                bump = hit;
                if (!pkt_active) begin
                    nxt_state = psemc_pkg::pkt_idle;
                end else if (hit) begin
                    nxt_state = psemc_pkg::pkt_counted;
                end
            end
            psemc_pkg::pkt_counted: begin
                // further errors in this packet are swallowed
                bump = hit & ~pkt_active;
                if (!pkt_active) begin
                    nxt_state = psemc_pkg::pkt_idle;
                end
            end
            default: begin
                nxt_state = psemc_pkg::pkt_idle;
            end
        endcase
        // plain add wraps all-ones back to zero
        nxt_count = bump ? count_ff + {{(WIDTH-1){1'b0}}, 1'b1} : count_ff;
        nxt_incr = bump;
        nxt_wrap = bump & (&count_ff);
        if (soft_clear) begin
            nxt_state = psemc_pkg::pkt_idle;
            nxt_count = '0;
            nxt_incr = 1'b0;
            nxt_wrap = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= psemc_pkg::pkt_idle;
            count_ff <= '0;
            incr_ff <= 1'b0;
            wrap_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            count_ff <= nxt_count;
            incr_ff <= nxt_incr;
            wrap_ff <= nxt_wrap;
        end
    end

    assign count = count_ff;
    assign incr_pulse = incr_ff;
    assign wrap_pulse = wrap_ff;

endmodule : psemc_symbol_counter

// ### verification/phy_symbol_error_and_mdix_ctrl_tb_top.sv
// self-checking bench for the symbol error / crossover register block
`timescale 1ns/1ps
module phy_symbol_error_and_mdix_ctrl_tb_top;
    localparam logic [7:0] A_CNT = 8'h68;
    localparam logic [7:0] A_SPC = 8'h6C;
    localparam logic [7:0] A_STS = 8'h70;
    localparam logic [7:0] A_MSK = 8'h74;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic phy_soft_reset = 1'b0, fiber_mode_strap = 1'b0, mode_100tx = 1'b1, mode_10t = 1'b0;
    logic rx_symbol_valid = 1'b0, rx_symbol_invalid = 1'b0, rx_packet_active = 1'b0;
    logic rx_polarity_reversed = 1'b0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, err, mdix_auto, mdix_crossed, heartbeat_test_enable, irq;
    logic far_end_fault_gen_enable, far_end_fault_det_enable;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    always #2.5 pclk = ~pclk;

    psemc_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phy_soft_reset(phy_soft_reset),
        .fiber_mode_strap(fiber_mode_strap), .mode_100tx(mode_100tx), .mode_10t(mode_10t),
        .rx_symbol_valid(rx_symbol_valid), .rx_symbol_invalid(rx_symbol_invalid),
        .rx_packet_active(rx_packet_active), .rx_polarity_reversed(rx_polarity_reversed),
        .mdix_auto(mdix_auto), .mdix_crossed(mdix_crossed),
        .heartbeat_test_enable(heartbeat_test_enable),
        .far_end_fault_gen_enable(far_end_fault_gen_enable),
        .far_end_fault_det_enable(far_end_fault_det_enable), .irq(irq));

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // a hang ends in the same closing report
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            wrap_up;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // entered and left just after a rising edge, so back-to-back calls never clash
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp, what);
    endtask : rd

    task automatic sym(input logic inv, input logic pkt);
        rx_symbol_valid <= 1'b1;
        rx_symbol_invalid <= inv;
        rx_packet_active <= pkt;
        @(posedge pclk);
        rx_symbol_valid <= 1'b0;
        rx_symbol_invalid <= 1'b0;
        @(posedge pclk);
    endtask : sym

    task automatic t_reset;
        rd(A_CNT, 32'h0, "count after reset");
        rd(A_SPC, 32'h0, "special after reset");
        chk({31'h0, heartbeat_test_enable}, 32'h1, "heartbeat on");
        apb(1'b0, 8'h69, 32'h0);
        chk({31'h0, err}, 32'h1, "misaligned refused");
        $display("test reset done");
    endtask : t_reset

    task automatic t_count;
        repeat (3) sym(1'b1, 1'b0);
        sym(1'b0, 1'b0);
        rd(A_CNT, 32'h3, "idle symbol errors");
        apb(1'b0, 8'h69, 32'h0);
        chk(rdata, 32'h0, "refused read is zero");
        repeat (3) sym(1'b1, 1'b1);
        rx_packet_active <= 1'b0;
        @(posedge pclk);
        rd(A_CNT, 32'h4, "one per packet");
        rd(A_CNT, 32'h4, "read leaves count");
        apb(1'b1, A_CNT, 32'hFFFF);
        rd(A_CNT, 32'h4, "count write ignored");
        mode_100tx <= 1'b0;
        mode_10t <= 1'b1;
        repeat (2) sym(1'b1, 1'b0);
        rd(A_CNT, 32'h4, "frozen at 10 Mb/s");
        mode_10t <= 1'b0;
        mode_100tx <= 1'b1;
        $display("test count done");
    endtask : t_count

    task automatic t_wrap;
        apb(1'b1, A_MSK, 32'h2);
        rx_symbol_valid <= 1'b1;
        rx_symbol_invalid <= 1'b1;
        // count stands at 4, so this brings it to all ones
        repeat (65531) @(posedge pclk);
        rx_symbol_valid <= 1'b0;
        rx_symbol_invalid <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0, "no wrap yet");
        rd(A_CNT, 32'hFFFF, "count at maximum");
        sym(1'b1, 1'b0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1, "wrap interrupt");
        rd(A_CNT, 32'h0, "count wrapped");
        apb(1'b1, A_MSK, 32'h0);
        chk({31'h0, irq}, 32'h0, "interrupt masked");
        apb(1'b1, A_STS, 32'h7);
        apb(1'b1, A_MSK, 32'h7);
        chk({31'h0, irq}, 32'h0, "status cleared");
        sym(1'b1, 1'b0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1, "count interrupt");
        rd(A_STS, 32'h1, "count event status");
        apb(1'b1, A_STS, 32'h1);
        rd(A_STS, 32'h0, "status after clear");
        chk({31'h0, irq}, 32'h0, "interrupt dropped");
        $display("test wrap done");
    endtask : t_wrap

    task automatic t_mdix;
        logic [2:0] c;
        logic [15:0] e;
        for (int i = 0; i < 7; i++) begin
            // enable and state both 1 is reserved, so software never writes it
            if (i == 3) continue;
            c = i[2:0];
            e = {c, 1'b0, c[0], 5'h0, c[1], 5'h0};
            apb(1'b1, A_SPC, {16'hFFFF, e | 16'h17DF});
            rd(A_SPC, {16'h0, e}, "special readback");
            chk({27'h0, mdix_auto, mdix_crossed, heartbeat_test_enable, far_end_fault_gen_enable,
                far_end_fault_det_enable}, {27'h0, !c[2] || (c[1] && !c[0]),
                c[2] && !c[1] && c[0], !c[0], c[1], c[1]}, "controls");
        end
        pstrb <= 4'h1;
        apb(1'b1, A_SPC, 32'h0);
        pstrb <= 4'hF;
        rd(A_SPC, 32'hC000, "low byte strobe only");
        $display("test crossover done");
    endtask : t_mdix

    task automatic t_soft;
        fiber_mode_strap <= 1'b1;
        apb(1'b1, A_SPC, 32'hA800);
        phy_soft_reset <= 1'b1;
        @(posedge pclk);
        phy_soft_reset <= 1'b0;
        @(posedge pclk);
        rd(A_SPC, 32'hA820, "kept over soft reset");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(A_SPC, 32'h20, "chip reset in fiber mode");
        mode_100tx <= 1'b0;
        mode_10t <= 1'b1;
        rx_polarity_reversed <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(A_SPC, 32'h30, "reversed polarity");
        rd(A_STS, 32'h4, "polarity change event");
        rx_polarity_reversed <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(A_SPC, 32'h20, "normal polarity");
        $display("test soft reset done");
    endtask : t_soft

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_count;
        t_wrap;
        t_mdix;
        t_soft;
        wrap_up;
    end
endmodule : phy_symbol_error_and_mdix_ctrl_tb_top

bind psemc_regs psemc_regs_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_soft_reset(phy_soft_reset), .fiber_mode_strap(fiber_mode_strap),
    .mdix_auto(mdix_auto), .mdix_crossed(mdix_crossed),
    .heartbeat_test_enable(heartbeat_test_enable),
    .far_end_fault_gen_enable(far_end_fault_gen_enable),
    .far_end_fault_det_enable(far_end_fault_det_enable), .irq(irq));

// ### verification/psemc_regs_properties.sv
// concurrent checks on the ports of the symbol error / crossover register block
`timescale 1ns/1ps
module psemc_regs_properties #(
    parameter int ADDR_WIDTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // port mode
    input wire logic phy_soft_reset,
    input wire logic fiber_mode_strap,
    // physical layer controls
    input wire logic mdix_auto,
    input wire logic mdix_crossed,
    input wire logic heartbeat_test_enable,
    input wire logic far_end_fault_gen_enable,
    input wire logic far_end_fault_det_enable,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_write;
        psel && penable && pwrite;
    endsequence

    fef_pair_a: assert property (
        far_end_fault_gen_enable == far_end_fault_det_enable)
        else $error("far-end fault enables disagree");
    mdix_legal_a: assert property (!(mdix_auto && mdix_crossed))
        else $error("automatic and crossed both selected");
    soft_keep_a: assert property (phy_soft_reset && !psel |=>
        $stable(mdix_auto) && $stable(mdix_crossed) && $stable(heartbeat_test_enable))
        else $error("soft reset disturbed crossover or heartbeat");
    soft_fef_a: assert property (phy_soft_reset && !psel |=>
        far_end_fault_gen_enable == $past(fiber_mode_strap))
        else $error("far-end fault enable not reloaded from strap");
    hb_hold_a: assert property (!(psel && penable && pwrite) |=>
        $stable(heartbeat_test_enable))
        else $error("heartbeat enable moved without a write");
    err_unmapped_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    reserved_zero_a: assert property (s_setup ##1 (penable && !pwrite && paddr == 8'h6C) |->
        (prdata & 32'hFFFF17CF) == 32'h0)
        else $error("reserved bits of special register not zero");
    zero_wait_a: assert property (s_setup ##1 penable |-> pready)
        else $error("access phase without ready");
    irq_masked_a: assert property (s_write ##0 (paddr == 8'h74 && pstrb[0] &&
        pwdata[2:0] == 3'h0) |=> !irq [*2])
        else $error("interrupt with all sources masked");
    fef_write_a: assert property (s_write ##0 (paddr == 8'h6C && pstrb[0] &&
        !phy_soft_reset) |=> far_end_fault_gen_enable == $past(pwdata[5]) &&
        far_end_fault_det_enable == $past(pwdata[5]))
        else $error("far-end fault enables do not follow the write");
    mdix_write_a: assert property (s_write ##0 (paddr == 8'h6C && pstrb[1] &&
        !(pwdata[14] && pwdata[13])) |=>
        mdix_auto == $past(!pwdata[15] || pwdata[14]) &&
        mdix_crossed == $past(pwdata[15] && !pwdata[14] && pwdata[13]))
        else $error("crossover selection does not follow the write");
endmodule : psemc_regs_properties
